/* odmpc_pkg.sv */
/*
 package for the output driver mode and power-on control block:
 register offsets, field positions, reset values and carrier types.
 assumes an apb slave with 32-bit data, one aligned word per register.
*/
package odmpc_pkg;
    localparam logic [11:0] ODMPC_CTRL_OFS   = 12'h000;
    localparam logic [11:0] ODMPC_STATUS_OFS = 12'h004;
    localparam logic [31:0] ODMPC_CTRL_RST   = 32'h0000_0000;
    // control register fields
    localparam int ODMPC_RANGE_LSB              = 0;
    localparam int ODMPC_RSET_BIT               = 4;
    localparam int ODMPC_CLEAR_VALUE_SELECT_BIT = 5;
    localparam int ODMPC_OUTPUT_ENABLE_BIT      = 6;
    localparam int ODMPC_CLEAR_BIT              = 7;
    localparam int ODMPC_RESET_BIT              = 8;
    // status register fields
    localparam int ODMPC_ST_HWMODE  = 0;
    localparam int ODMPC_ST_VEN     = 1;
    localparam int ODMPC_ST_IEN     = 2;
    localparam int ODMPC_ST_VZERO   = 3;
    localparam int ODMPC_ST_CLRACT  = 4;
    localparam int ODMPC_ST_BADRNG  = 5;
    localparam int ODMPC_ST_SAMPLED = 6;
    localparam int ODMPC_ST_RANGE   = 8;

    typedef struct packed {
        logic [3:0] range;
        logic       rset;
        logic       clear_value_select;
        logic       output_enable;
        logic       soft_clear;
    } odmpc_ctrl_type;

    typedef struct packed {
        logic       voltage_enable;
        logic       current_enable;
        logic       voltage_zero;
        logic       clear_active;
        logic       bipolar;
        logic [3:0] range;
    } odmpc_out_type;
endpackage

/* odmpc_top.sv */
/*
 output driver mode and power-on control: apb register slave, mode
 sampling at power-up, range decode and output channel enables.
 assumes pins are asynchronous to pclk; analog path lies outside.
*/
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module odmpc_top (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  interface_mode_select,
    input  wire logic                  clear_pin,
    input  wire logic                  reset_pin_n,
    input  wire logic                  output_enable_pin,
    input  wire logic                  clear_value_select_pin,
    input  wire logic [3:0]            range_strap,
    input  wire logic                  rset_strap,
    output odmpc_pkg::odmpc_out_type   out_ctl
);
    typedef enum logic [1:0] {
        ODMPC_ST_WAIT = 2'b00,
        ODMPC_ST_FILL = 2'b01,
        ODMPC_ST_SYNC = 2'b11,
        ODMPC_ST_RUN  = 2'b10
    } odmpc_phase_type;

    typedef struct packed {
        logic [1:0]                 hw_s;
        logic [1:0]                 clr_s;
        logic [1:0]                 rst_s;
        logic [1:0]                 oen_s;
        logic [1:0]                 csel_s;
        logic [9:0]                 strap_s;
        odmpc_phase_type            phase;
        logic                       hw_mode;
        logic                       clr_at_pu;
        odmpc_pkg::odmpc_ctrl_type  ctrl;
        odmpc_pkg::odmpc_out_type   outs;
        logic [31:0]                rdata;
    } odmpc_state_type;

    odmpc_state_type s_q;
    odmpc_state_type s_d;

    // valid range codes: five current then four voltage
    function automatic logic range_valid(input logic [3:0] r);
        range_valid = (r <= 4'h8);
    endfunction
    function automatic logic range_is_voltage(input logic [3:0] r);
        range_is_voltage = (r >= 4'h5) && (r <= 4'h8);
    endfunction
    function automatic logic range_is_bipolar(input logic [3:0] r);
        range_is_bipolar = (r == 4'h3) || (r == 4'h4) ||
                           (r == 4'h7) || (r == 4'h8);
    endfunction

    logic        wr_ctrl;
    logic        rd_hit;
    logic        hw_lvl;
    logic        clr_lvl;
    logic        rst_lvl_n;
    logic [3:0]  eff_range;
    logic        eff_en;
    logic        eff_clear_value_select;
    logic        clr_now;

    assign hw_lvl    = s_q.hw_s[1];
    assign clr_lvl   = s_q.clr_s[1] | s_q.ctrl.soft_clear;
    assign rst_lvl_n = s_q.rst_s[1];
    assign wr_ctrl   = psel && penable && pwrite &&
                       (paddr == odmpc_pkg::ODMPC_CTRL_OFS);
    assign rd_hit    = (paddr == odmpc_pkg::ODMPC_CTRL_OFS) ||
                       (paddr == odmpc_pkg::ODMPC_STATUS_OFS);

    // hardware mode takes straps, software mode takes the register
    assign eff_range  = s_q.hw_mode ? s_q.strap_s[9:6]
                                    : s_q.ctrl.range;
    assign eff_en     = s_q.hw_mode ? s_q.oen_s[1]
                                    : s_q.ctrl.output_enable;
    assign eff_clear_value_select = s_q.hw_mode ? s_q.csel_s[1]
                                    : s_q.ctrl.clear_value_select;
    assign clr_now    = clr_lvl;

    always_comb begin
        s_d = s_q;
        // two-stage synchronisers, first stage read only by second
        s_d.hw_s    = {s_q.hw_s[0], interface_mode_select};
        s_d.clr_s   = {s_q.clr_s[0], clear_pin};
        s_d.rst_s   = {s_q.rst_s[0], reset_pin_n};
        s_d.oen_s   = {s_q.oen_s[0], output_enable_pin};
        s_d.csel_s  = {s_q.csel_s[0], clear_value_select_pin};
        s_d.strap_s = {s_q.strap_s[4:0], range_strap, rset_strap};

        case (s_q.phase)
            ODMPC_ST_WAIT: begin
                s_d.phase = ODMPC_ST_FILL;
            end
            ODMPC_ST_FILL: begin
                // second stage still holds the reset zero here
                s_d.phase = ODMPC_ST_SYNC;
            end
            ODMPC_ST_SYNC: begin
                // mode and clear caught once synchronisers are full
                s_d.hw_mode   = hw_lvl;
                s_d.clr_at_pu = s_q.clr_s[1];
                s_d.phase     = ODMPC_ST_RUN;
            end
            ODMPC_ST_RUN: begin
                if (!s_q.hw_mode) begin
                    if (wr_ctrl) begin
                        // enable and range arrive in one write
                        s_d.ctrl.range = pwdata[odmpc_pkg::ODMPC_RANGE_LSB
                                               +: 4];
                        s_d.ctrl.rset  =
                            pwdata[odmpc_pkg::ODMPC_RSET_BIT];
                        s_d.ctrl.clear_value_select =
                            pwdata[odmpc_pkg::ODMPC_CLEAR_VALUE_SELECT_BIT];
                        s_d.ctrl.output_enable =
                            pwdata[odmpc_pkg::ODMPC_OUTPUT_ENABLE_BIT];
                        s_d.ctrl.soft_clear =
                            pwdata[odmpc_pkg::ODMPC_CLEAR_BIT];
                        // leaving power-up state drops the 0 V hold
                        if (pwdata[odmpc_pkg::ODMPC_OUTPUT_ENABLE_BIT]) begin
                            s_d.clr_at_pu = 1'b0;
                        end
                    end
                    // reset bit self-clears, reset pin is a level
                    if ((wr_ctrl && pwdata[odmpc_pkg::ODMPC_RESET_BIT])
                        || !rst_lvl_n) begin
                        s_d.ctrl      = odmpc_pkg::odmpc_ctrl_type'(
                                        odmpc_pkg::ODMPC_CTRL_RST[7:0]);
                        s_d.clr_at_pu = s_q.clr_s[1];
                    end
                end
            end
            default: begin
                s_d.phase = ODMPC_ST_WAIT;
            end
        endcase

        // output channel decode
        s_d.outs = '0;
        s_d.outs.range   = eff_range;
        s_d.outs.bipolar = range_is_bipolar(eff_range);
        if (s_q.phase != ODMPC_ST_RUN) begin
            s_d.outs = '0;
        end else if (eff_en && range_valid(eff_range)) begin
            // exactly one channel from the range class
            s_d.outs.voltage_enable = range_is_voltage(eff_range);
            s_d.outs.current_enable = !range_is_voltage(eff_range);
            s_d.outs.clear_active   = clr_now;
            s_d.outs.voltage_zero   = clr_now && !eff_clear_value_select &&
                                      range_is_voltage(eff_range);
        end else if (!s_q.hw_mode && s_q.clr_at_pu) begin
            // powered up with clear high: hold 0 V on voltage pin
            s_d.outs.voltage_enable = 1'b1;
            s_d.outs.voltage_zero   = 1'b1;
            s_d.outs.current_enable = 1'b0;
        end else begin
            s_d.outs.voltage_enable = 1'b0;
            s_d.outs.current_enable = 1'b0;
        end

        // read data registered in setup so access phase has it
        s_d.rdata = '0;
        if (psel && !penable && !pwrite) begin
            if (paddr == odmpc_pkg::ODMPC_CTRL_OFS) begin
                s_d.rdata[odmpc_pkg::ODMPC_RANGE_LSB +: 4] = s_q.ctrl.range;
                s_d.rdata[odmpc_pkg::ODMPC_RSET_BIT]   = s_q.ctrl.rset;
                s_d.rdata[odmpc_pkg::ODMPC_CLEAR_VALUE_SELECT_BIT] =
                    s_q.ctrl.clear_value_select;
                s_d.rdata[odmpc_pkg::ODMPC_OUTPUT_ENABLE_BIT] =
                    s_q.ctrl.output_enable;
                s_d.rdata[odmpc_pkg::ODMPC_CLEAR_BIT]  =
                    s_q.ctrl.soft_clear;
            end else if (paddr == odmpc_pkg::ODMPC_STATUS_OFS) begin
                s_d.rdata[odmpc_pkg::ODMPC_ST_HWMODE] = s_q.hw_mode;
                s_d.rdata[odmpc_pkg::ODMPC_ST_VEN] =
                    s_q.outs.voltage_enable;
                s_d.rdata[odmpc_pkg::ODMPC_ST_IEN] =
                    s_q.outs.current_enable;
                s_d.rdata[odmpc_pkg::ODMPC_ST_VZERO] =
                    s_q.outs.voltage_zero;
                s_d.rdata[odmpc_pkg::ODMPC_ST_CLRACT] =
                    s_q.outs.clear_active;
                s_d.rdata[odmpc_pkg::ODMPC_ST_BADRNG] =
                    !range_valid(eff_range);
                s_d.rdata[odmpc_pkg::ODMPC_ST_SAMPLED] =
                    (s_q.phase == ODMPC_ST_RUN);
                s_d.rdata[odmpc_pkg::ODMPC_ST_RANGE +: 4] = eff_range;
            end
        end
    end

    // every field zero at power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // no wait states: answer in the first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !rd_hit;
    assign prdata  = s_q.rdata;
    assign out_ctl = s_q.outs;
endmodule

/* odmpc_top_sva.sv */
/* checks on odmpc_top ports: one output at a time, range decode, apb answer.
 assumes pins settle before any control write and stay put during it. */
`timescale 1ns/1ps
module odmpc_top_sva (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    interface_mode_select,
    input wire logic                    clear_pin,
    input wire logic                    reset_pin_n,
    input wire odmpc_pkg::odmpc_out_type out_ctl
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic sw_wr;
    // clear and reset pin excluded: the reset pin overrides the write
    assign sw_wr = psel && penable && pwrite && paddr == 12'h000
        && !interface_mode_select && !clear_pin && reset_pin_n;
    one_output_a: assert property (!(out_ctl.voltage_enable
        && out_ctl.current_enable)) else $error("both outputs on");
    release_zero_a: assert property ($rose(presetn) |-> out_ctl == '0)
        else $error("outputs not zero after reset");
    write_range_a: assert property (sw_wr && pwdata[8:6] == 3'h1 && !pwdata[4]
        && pwdata[3:0] <= 4'h8 |=> ##1 out_ctl.range == $past(pwdata[3:0], 2))
        else $error("range not taken from write");
    cur_range_a: assert property (out_ctl.current_enable
        |-> out_ctl.range <= 4'h4) else $error("current on bad range");
    volt_range_a: assert property (out_ctl.voltage_enable |-> out_ctl.range
        inside {[4'h5:4'h8]} || (out_ctl.voltage_zero
        && !out_ctl.clear_active)) else $error("voltage on bad range");
    disable_a: assert property (sw_wr && !pwdata[6] |=> ##1
        !(out_ctl.voltage_enable || out_ctl.current_enable))
        else $error("output left on");
    hw_ignore_a: assert property (psel && penable && pwrite
        && interface_mode_select |=> ##1 $stable(out_ctl))
        else $error("write taken in hardware mode");
    reset_pin_a: assert property ((!interface_mode_select && !clear_pin
        && !reset_pin_n) [*5] |-> !(out_ctl.voltage_enable
        || out_ctl.current_enable)) else $error("reset pin ignored");
    slverr_a: assert property (psel && penable |-> pready && pslverr
        == !(paddr inside {12'h000, 12'h004})) else $error("bad apb answer");
endmodule
bind odmpc_top odmpc_top_sva i_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .interface_mode_select(interface_mode_select), .clear_pin(clear_pin),
    .reset_pin_n(reset_pin_n), .out_ctl(out_ctl));

/* odmpc_pin_model.sv */
/* model of the controlling processor's pins: mode, clear, reset, straps.
 assumes the bench sets levels between transfers, clocked by pclk. */
`timescale 1ns/1ps
module odmpc_pin_model (
    input  wire logic  pclk,
    output logic       interface_mode_select,
    output logic       clear_pin,
    output logic       reset_pin_n,
    output logic       output_enable_pin,
    output logic       clear_value_select_pin,
    output logic [3:0] range_strap,
    output logic       rset_strap
);
    initial {interface_mode_select, clear_pin, reset_pin_n, output_enable_pin,
        clear_value_select_pin, range_strap, rset_strap} = 10'h080;
    // clear low for normal use, strap enable low at hw power-up
    task automatic set_pins(input logic hw, c, rn, oe, input logic [3:0] r);
        @(posedge pclk);
        {interface_mode_select, clear_pin, reset_pin_n, output_enable_pin,
            range_strap} <= {hw, c, rn, oe, r};
    endtask
endmodule

/* output_driver_mode_poweron_ctrl_test.sv */
/* self-checking bench for odmpc_top over apb and the pin model.
 assumes pready answers within 20 cycles; pins change only in idle. */
`timescale 1ns/1ps
module output_driver_mode_poweron_ctrl_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        mode, clr, rstn, oe, cvs, rset;
    logic [3:0]  rng;
    odmpc_pkg::odmpc_out_type oc;
    int          n_errors = 0;
    int          n_checks = 0;
    odmpc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .interface_mode_select(mode), .clear_pin(clr), .reset_pin_n(rstn),
        .output_enable_pin(oe), .clear_value_select_pin(cvs),
        .range_strap(rng), .rset_strap(rset), .out_ctl(oc));
    odmpc_pin_model i_pins (.pclk(pclk), .interface_mode_select(mode),
        .clear_pin(clr), .reset_pin_n(rstn), .output_enable_pin(oe),
        .clear_value_select_pin(cvs), .range_strap(rng), .rset_strap(rset));
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_out(input logic [3:0] code, input logic en);
        logic v, c;
        v = en && code inside {[4'h5:4'h8]};
        c = en && code <= 4'h4;
        chk("enables", {30'h0, v, c}, {30'h0, oc.voltage_enable,
            oc.current_enable});
        if (v || c) chk("range", {28'h0, code}, {28'h0, oc.range});
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (i == 20) begin
            n_errors++;
            test_done();
        end
    endtask
    task automatic settle();
        repeat (6) @(posedge pclk);
        #1;
    endtask
    // pins held three cycles before release; the syncs stay zero in reset and fill only after it
    task automatic power_up(input logic hw, c, oe_p, input logic [3:0] r);
        i_pins.set_pins(hw, c, 1'b1, oe_p, r);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        settle();
    endtask
    task automatic t_software();
        power_up(0, 0, 0, 4'h0);
        chk_out(4'h0, 0);
        xfer(0, 12'h000, 0);
        chk("ctrl reset", 0, rd);
        for (int k = 0; k < 10; k++) begin
            xfer(1, 12'h000, 32'h40 | k);
            settle();
            chk_out(k[3:0], 1);
        end
        xfer(0, 12'h000, 0);
        chk("ctrl", 32'h49, rd);
        xfer(1, 12'h000, 32'h05);
        settle();
        chk_out(4'h5, 0);
        xfer(1, 12'h000, 32'h45);
        xfer(1, 12'h000, 32'h100);
        settle();
        chk_out(4'h5, 0);
        xfer(0, 12'h000, 0);
        chk("reset bit", 0, rd & 32'h140);
        xfer(1, 12'h000, 32'h42);
        i_pins.set_pins(0, 0, 0, 0, 4'h0);
        settle();
        chk_out(4'h2, 0);
        i_pins.set_pins(0, 0, 1, 0, 4'h0);
        xfer(1, 12'h008, 0);
        chk("slverr", 1, err);
        xfer(1, 12'h004, 32'hFFFF);
        chk("status ok", 0, err);
    endtask
    task automatic t_clear_high();
        power_up(0, 1, 0, 4'h0);
        chk("zero hold", 32'h3, {oc.current_enable, oc.voltage_enable,
            oc.voltage_zero});
        xfer(1, 12'h000, 32'h45);
        settle();
        chk("clear state", 1, oc.clear_active);
        chk("clear zero", 1, oc.voltage_zero);
        xfer(1, 12'h000, 32'h65);
        settle();
        chk("clear value sel", 0, oc.voltage_zero);
        i_pins.set_pins(0, 0, 1, 0, 4'h0);
        settle();
        chk("clear left", 0, oc.clear_active);
        chk_out(4'h5, 1);
        xfer(1, 12'h000, 32'hC5);
        settle();
        chk("soft clear", 1, oc.clear_active);
    endtask
    task automatic t_hardware();
        power_up(1, 0, 0, 4'h6);
        chk_out(4'h6, 0);
        i_pins.set_pins(1, 0, 1, 1, 4'h6);
        settle();
        chk_out(4'h6, 1);
        xfer(0, 12'h004, 0);
        chk("status", 32'h643, rd);
        xfer(1, 12'h000, 32'h40);
        settle();
        chk_out(4'h6, 1);
        power_up(1, 0, 0, 4'h1);
        chk_out(4'h1, 0);
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        t_software();
        t_clear_high();
        t_hardware();
        test_done();
    end
endmodule
